// ### core/dsc_pkg.sv
// Shared constants for the instruction format decoder
package dsc_pkg;
   // Word geometry
   localparam int INSTR_W  = 24;
   localparam int OPC_W    = 8;
   localparam int OPC_LSB  = 16;
   localparam int REG_W    = 4;
   localparam int FLAG_W   = 9;
   localparam int DATA_W   = 16;
   localparam int ADDR_W   = 4;
   localparam int TGT_W    = 23;
   localparam int TGT_LO_W = 16;
   localparam int TGT_HI_W = 7;
   // Operand field positions
   localparam int WS_LSB   = 0;
   localparam int WD_LSB   = 4;
   localparam int WB_LSB   = 8;
   localparam int FADDR_W  = 13;
   localparam int FDEST_BIT = 13;
   localparam int BYTE_BIT = 14;
   localparam int LIT_LSB  = 4;
   localparam int LIT_W    = 10;
   localparam int BSEL_LSB = 12;
   localparam int ACC_BIT  = 15;
   localparam int PAIR_LSB = 12;
   localparam int XPF_LSB  = 8;
   localparam int YPF_LSB  = 4;
   localparam int XD_LSB   = 2;
   localparam int YD_LSB   = 0;
   // Opcodes, upper byte of the word
   localparam logic [7:0] OPC_NOP    = 8'h00;
   localparam logic [7:0] OPC_FILE   = 8'h10;
   localparam logic [7:0] OPC_WORK   = 8'h20;
   localparam logic [7:0] OPC_LIT    = 8'h30;
   localparam logic [7:0] OPC_BIT    = 8'h40;
   localparam logic [7:0] OPC_SKIP   = 8'h41;
   localparam logic [7:0] OPC_BRAC   = 8'h50;
   localparam logic [7:0] OPC_BRA    = 8'h51;
   localparam logic [7:0] OPC_BRAW   = 8'h52;
   localparam logic [7:0] OPC_CALLW  = 8'h53;
   localparam logic [7:0] OPC_GOTOW  = 8'h54;
   localparam logic [7:0] OPC_TBLRD  = 8'h55;
   localparam logic [7:0] OPC_TBLWT  = 8'h56;
   localparam logic [7:0] OPC_RETURN = 8'h57;
   localparam logic [7:0] OPC_MOVD   = 8'h60;
   localparam logic [7:0] OPC_CALL2  = 8'h70;
   localparam logic [7:0] OPC_GOTO2  = 8'h71;
   localparam logic [7:0] OPC_DO2    = 8'h72;
   localparam logic [5:0] OPC_SQR_HI = 6'h20;
   localparam logic [5:0] OPC_MAC_HI = 6'h30;
   // Cycle counts
   localparam logic [1:0] CYC_1 = 2'h1;
   localparam logic [1:0] CYC_2 = 2'h2;
   localparam logic [1:0] CYC_3 = 2'h3;
   // Fixed registers
   localparam logic [3:0] FILE_DEF_REG = 4'h0;
   localparam logic [3:0] W_DSP_BASE   = 4'h4;
   localparam logic [3:0] X_PF_BASE    = 4'h8;
   localparam logic [3:0] Y_PF_BASE    = 4'hA;
   localparam logic [3:0] PF_OFS_REG   = 4'hC;
   localparam logic [3:0] ACC_WB_REG   = 4'hD;
   localparam logic [3:0] ACC_WB_INC   = 4'h2;
   localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
   // Write-back modes
   localparam logic [1:0] WB_NONE = 2'h0;
   localparam logic [1:0] WB_DIR  = 2'h1;
   localparam logic [1:0] WB_IND  = 2'h2;
   // Status flag bits and per-class masks
   localparam int F_Z = 4;
   localparam logic [8:0] MASK_ARITH = 9'h01F;
   localparam logic [8:0] MASK_LOGIC = 9'h014;
   localparam logic [8:0] MASK_DSP   = 9'h1E0;
   // Register map and error bits
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_STAT = 4'h1;
   localparam logic [3:0] A_ERR  = 4'h2;
   localparam logic [3:0] A_LAST = 4'h3;
   localparam int E_ILL = 0;
   localparam int E_LIT = 1;
   localparam int E_LSB = 2;
   localparam int E_W2  = 3;
   localparam int ERR_W = 4;
   localparam logic CTRL_RST = 1'b1;
   typedef enum logic [3:0] {CL_NOP, CL_FILE, CL_WORK, CL_LIT, CL_BIT, CL_SKIP, CL_BRANCH,
                             CL_CTRL, CL_MOVD, CL_LONG, CL_DSP, CL_ILLEGAL} dsc_class_e;
   typedef enum {ST_FETCH, ST_WORD2} dsc_state_e;
endpackage

// ### core/dsc_decode.sv
// Instruction word decoder with status flags and register port
`timescale 1ns/1ps
module dsc_decode
   import dsc_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst,
   input  wire logic              i_instr_valid,
   input  wire logic [23:0]       i_instr_word,
   input  wire logic [23:0]       i_next_word,
   input  wire logic              i_cond_true,
   input  wire logic              i_res_valid,
   input  wire logic [8:0]        i_res_flags,
   input  wire logic              i_res_z_sticky,
   input  wire logic [3:0]        i_addr,
   input  wire logic [15:0]       i_wr_data,
   input  wire logic              i_wr_en,
   input  wire logic              i_rd_en,
   output logic [15:0]            o_rd_data,
   output logic                   o_dec_valid,
   output dsc_class_e             o_class,
   output logic [1:0]             o_cycles,
   output logic [3:0]             o_wb,
   output logic [3:0]             o_ws,
   output logic [3:0]             o_wd,
   output logic                   o_dest_file,
   output logic [12:0]            o_file_addr,
   output logic                   o_byte_mode,
   output logic [9:0]             o_ten_bit_literal,
   output logic [3:0]             o_bit_select_field,
   output logic [22:0]            o_call_target_literal,
   output logic                   o_acc_sel,
   output logic [3:0]             o_mul_a,
   output logic [3:0]             o_mul_b,
   output logic                   o_x_en,
   output logic [3:0]             o_x_prefetch_addr_sel,
   output logic [3:0]             o_x_adj,
   output logic                   o_x_ofs_w12,
   output logic [3:0]             o_x_dst,
   output logic                   o_y_en,
   output logic [3:0]             o_y_prefetch_addr_sel,
   output logic [3:0]             o_y_adj,
   output logic                   o_y_ofs_w12,
   output logic [3:0]             o_y_dst,
   output logic [1:0]             o_acc_writeback_dest,
   output logic [3:0]             o_acc_wb_reg,
   output logic [3:0]             o_acc_wb_inc,
   output logic [8:0]             o_flag_mask,
   output logic [8:0]             o_status
);

   // Prefetch field decode: {enable, register, signed adjust, offset by W12}
   function automatic logic [9:0] pf_dec(input logic [3:0] code, input logic [3:0] base);
      logic [3:0] adj;
      logic [3:0] rsel;
      adj  = 4'h0;
      rsel = base + {3'h0, code[3]};
      case (code[2:0])
         3'h0:    adj = 4'h6;
         3'h1:    adj = 4'h4;
         3'h2:    adj = 4'h2;
         3'h4:    adj = 4'hA;
         3'h5:    adj = 4'hC;
         3'h6:    adj = 4'hE;
         default: adj = 4'h0;
      endcase
      if (code == 4'hF)
         pf_dec = 10'h000;
      else
         pf_dec = {1'b1, rsel, adj, code[2:0] == 3'h7};
   endfunction

   // Only the three long opcodes span two words
   function automatic logic is_long(input logic [7:0] op);
      is_long = (op == OPC_CALL2) || (op == OPC_GOTO2) || (op == OPC_DO2);
   endfunction

   dsc_state_e         state_ff;
   dsc_state_e         nxt_state;
   logic               ctrl_en_ff;
   logic [ERR_W-1:0]   err_ff;
   logic [ERR_W-1:0]   nxt_err_set;
   logic [15:0]        first_lo_ff;
   logic [7:0]         last_opc_ff;
   logic [7:0]         opc;
   logic [23:0]        w;
   logic               take;
   logic [9:0]         xpf;
   logic [9:0]         ypf;
   logic [15:0]        nxt_rd_data;
   logic [8:0]         nxt_status;
   logic               nxt_dec_valid;
   dsc_class_e         nxt_class;
   logic [1:0]         nxt_cycles;
   logic [3:0]         nxt_mul_a;
   logic [3:0]         nxt_mul_b;
   logic [1:0]         nxt_acc_wb;
   logic [8:0]         nxt_mask;
   logic [22:0]        nxt_target;

   assign w    = i_instr_word;
   assign opc  = w[OPC_LSB +: OPC_W];
   assign take = i_instr_valid;
   assign xpf  = pf_dec(w[XPF_LSB +: REG_W], X_PF_BASE);
   assign ypf  = pf_dec(w[YPF_LSB +: REG_W], Y_PF_BASE);

   // Word sequencing: a long opcode waits for its second word
   always_comb
   begin
      nxt_state = state_ff;
      if (take && ctrl_en_ff)
      begin
         if (state_ff == ST_FETCH && is_long(opc))
            nxt_state = ST_WORD2;
         else
            nxt_state = ST_FETCH;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         state_ff <= ST_FETCH;
      else
         state_ff <= nxt_state;
   end

   // First word of a long instruction holds the low target bits
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         first_lo_ff <= 16'h0000;
      else if (take && state_ff == ST_FETCH)
         first_lo_ff <= w[TGT_LO_W-1:0];
   end

   // Class, cycle count, multiply pair, write-back and flag mask
   always_comb
   begin
      nxt_dec_valid = 1'b0;
      nxt_class     = CL_NOP;
      nxt_cycles    = CYC_1;
      nxt_mul_a     = W_DSP_BASE;
      nxt_mul_b     = W_DSP_BASE;
      nxt_acc_wb    = WB_NONE;
      nxt_mask      = 9'h000;
      nxt_target    = {w[TGT_HI_W-1:0], first_lo_ff};
      nxt_err_set   = '0;
      if (take && state_ff == ST_WORD2)
      begin
         nxt_dec_valid = 1'b1;
         nxt_class     = CL_LONG;
         nxt_cycles    = CYC_2;
         nxt_err_set[E_W2]  = (opc != OPC_NOP);
         nxt_err_set[E_LSB] = first_lo_ff[0];
      end
      else if (take && !ctrl_en_ff)
         nxt_dec_valid = 1'b1;                               // Disabled core sees NOPs
      else if (take)
      begin
         nxt_dec_valid = !is_long(opc);
         case (opc)
            OPC_NOP:  nxt_class = CL_NOP;
            OPC_FILE:
            begin
               nxt_class = CL_FILE;
               nxt_mask  = MASK_ARITH;
            end
            OPC_WORK:
            begin
               nxt_class = CL_WORK;
               nxt_mask  = MASK_ARITH;
            end
            OPC_LIT:
            begin
               nxt_class = CL_LIT;
               nxt_mask  = MASK_LOGIC;
               nxt_err_set[E_LIT] = w[BYTE_BIT] && (w[LIT_LSB +: LIT_W] > BYTE_LIT_MAX);
            end
            OPC_BIT:  nxt_class = CL_BIT;
            OPC_SKIP:
            begin
               nxt_class = CL_SKIP;
               if (i_cond_true)
                  nxt_cycles = is_long(i_next_word[OPC_LSB +: OPC_W]) ? CYC_3 : CYC_2;
            end
            OPC_BRAC:
            begin
               nxt_class  = CL_BRANCH;
               nxt_cycles = i_cond_true ? CYC_2 : CYC_1;
            end
            OPC_BRA, OPC_BRAW, OPC_CALLW, OPC_GOTOW, OPC_TBLRD, OPC_TBLWT:
            begin
               nxt_class  = CL_CTRL;
               nxt_cycles = CYC_2;
            end
            OPC_RETURN:
            begin
               nxt_class  = CL_CTRL;
               nxt_cycles = CYC_3;
            end
            OPC_MOVD:
            begin
               nxt_class  = CL_MOVD;
               nxt_cycles = CYC_2;
            end
            OPC_CALL2, OPC_GOTO2, OPC_DO2: nxt_class = CL_LONG;
            default:
            begin
               nxt_class = CL_ILLEGAL;
               if (opc[7:2] == OPC_SQR_HI || opc[7:2] == OPC_MAC_HI)
               begin
                  nxt_class = CL_DSP;
                  nxt_mask  = MASK_DSP;
                  nxt_acc_wb = opc[1:0];
                  if (opc[1:0] == 2'h3)
                     nxt_class = CL_ILLEGAL;
               end
               if (opc[7:2] == OPC_SQR_HI)
               begin
                  nxt_mul_a = W_DSP_BASE + {2'h0, w[PAIR_LSB +: 2]};
                  nxt_mul_b = W_DSP_BASE + {2'h0, w[PAIR_LSB +: 2]};
               end
               else if (opc[7:2] == OPC_MAC_HI)
               begin
                  case (w[PAIR_LSB +: 3])
                     3'h0: nxt_mul_b = 4'h5;
                     3'h1: nxt_mul_b = 4'h6;
                     3'h2: nxt_mul_b = 4'h7;
                     3'h3: {nxt_mul_a, nxt_mul_b} = 8'h56;
                     3'h4: {nxt_mul_a, nxt_mul_b} = 8'h57;
                     3'h5: {nxt_mul_a, nxt_mul_b} = 8'h67;
                     default: nxt_class = CL_ILLEGAL;
                  endcase
               end
               if (nxt_class == CL_ILLEGAL)
               begin
                  nxt_acc_wb = WB_NONE;
                  nxt_mask = 9'h000;
               end
               nxt_err_set[E_ILL] = (nxt_class == CL_ILLEGAL);
            end
         endcase
      end
   end

   // Decode outputs, all registered one edge after the word is offered
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_dec_valid           <= 1'b0;
         o_class               <= CL_NOP;
         o_cycles              <= CYC_1;
         o_mul_a               <= W_DSP_BASE;
         o_mul_b               <= W_DSP_BASE;
         o_acc_writeback_dest  <= WB_NONE;
         o_flag_mask           <= 9'h000;
         o_call_target_literal <= 23'h000000;
      end
      else
      begin
         o_dec_valid           <= nxt_dec_valid;
         // Results stand until the next taken word, so late flag returns still meet their mask
         if (take)
         begin
            o_class               <= nxt_class;
            o_cycles              <= nxt_cycles;
            o_mul_a               <= nxt_mul_a;
            o_mul_b               <= nxt_mul_b;
            o_acc_writeback_dest  <= nxt_acc_wb;
            o_flag_mask           <= nxt_mask;
            if (nxt_class == CL_LONG && nxt_dec_valid)
               o_call_target_literal <= nxt_target;
         end
      end
   end

   // Operand fields are latched from the first word; prefetch codes are decoded and a file op without FDEST_BIT steers o_wd to W0
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         {o_wb, o_ws, o_wd}    <= 12'h000;
         o_dest_file           <= 1'b0;
         o_file_addr           <= 13'h0000;
         o_byte_mode           <= 1'b0;
         o_ten_bit_literal     <= 10'h000;
         o_bit_select_field    <= 4'h0;
         o_acc_sel             <= 1'b0;
         {o_x_en, o_x_prefetch_addr_sel, o_x_adj, o_x_ofs_w12} <= 10'h000;
         {o_y_en, o_y_prefetch_addr_sel, o_y_adj, o_y_ofs_w12} <= 10'h000;
         o_x_dst               <= W_DSP_BASE;
         o_y_dst               <= W_DSP_BASE;
         o_acc_wb_reg          <= ACC_WB_REG;
         o_acc_wb_inc          <= ACC_WB_INC;
      end
      else if (take && state_ff == ST_FETCH)
      begin
         o_wb        <= w[WB_LSB +: REG_W];
         o_ws        <= w[WS_LSB +: REG_W];
         o_dest_file <= (opc == OPC_FILE) && w[FDEST_BIT];
         if (opc == OPC_FILE && !w[FDEST_BIT])
            o_wd <= FILE_DEF_REG;
         else
            o_wd <= w[WD_LSB +: REG_W];
         o_file_addr <= w[FADDR_W-1:0];
         o_byte_mode <= w[BYTE_BIT];
         if (w[BYTE_BIT])
            o_ten_bit_literal <= {2'h0, w[LIT_LSB +: 8]};
         else
            o_ten_bit_literal <= w[LIT_LSB +: LIT_W];
         o_bit_select_field <= w[BSEL_LSB +: REG_W];
         o_acc_sel   <= w[ACC_BIT];
         {o_x_en, o_x_prefetch_addr_sel, o_x_adj, o_x_ofs_w12} <= xpf;
         {o_y_en, o_y_prefetch_addr_sel, o_y_adj, o_y_ofs_w12} <= ypf;
         o_x_dst     <= W_DSP_BASE + {2'h0, w[XD_LSB +: 2]};
         o_y_dst     <= W_DSP_BASE + {2'h0, w[YD_LSB +: 2]};
         o_acc_wb_reg <= ACC_WB_REG;
         o_acc_wb_inc <= ACC_WB_INC;
      end
   end

   // Status flags: execution results win over a software write in the same cycle
   generate
      for (genvar b = 0; b < FLAG_W; b++)
      begin : g_flag
         always_comb
         begin
            nxt_status[b] = o_status[b];
            if (i_wr_en && i_addr == A_STAT)
               nxt_status[b] = i_wr_data[b];
            if (i_res_valid && o_flag_mask[b])
            begin
               if (b == F_Z && i_res_z_sticky)
                  nxt_status[b] = o_status[b] & i_res_flags[b];
               else
                  nxt_status[b] = i_res_flags[b];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         o_status <= 9'h000;
      else
         o_status <= nxt_status;
   end

   // Control enable and sticky errors; a new error wins over write-one-to-clear
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_en_ff  <= CTRL_RST;
         err_ff      <= '0;
         last_opc_ff <= OPC_NOP;
      end
      else
      begin
         if (i_wr_en && i_addr == A_CTRL)
            ctrl_en_ff <= i_wr_data[0];
         if (i_wr_en && i_addr == A_ERR)
            err_ff <= (err_ff & ~i_wr_data[ERR_W-1:0]) | nxt_err_set;
         else
            err_ff <= err_ff | nxt_err_set;
         if (take)
            last_opc_ff <= opc;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_comb
   begin
      nxt_rd_data = 16'h0000;
      if (i_rd_en)
      begin
         case (i_addr)
            A_CTRL:  nxt_rd_data = {15'h0000, ctrl_en_ff};
            A_STAT:  nxt_rd_data = {7'h00, o_status};
            A_ERR:   nxt_rd_data = {12'h000, err_ff};
            A_LAST:  nxt_rd_data = {2'h0, o_class, o_cycles, last_opc_ff};
            default: nxt_rd_data = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         o_rd_data <= 16'h0000;
      else
         o_rd_data <= nxt_rd_data;
   end

   property p_word2_nop;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && state_ff == ST_WORD2) |=> (o_dec_valid && o_class == CL_LONG && o_cycles == CYC_2);
   endproperty
   a_word2_nop: assert property (p_word2_nop) else $error("second word not decoded as long");

   property p_brc;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && ctrl_en_ff && state_ff == ST_FETCH && opc == OPC_BRAC)
         |=> (o_cycles == ($past(i_cond_true) ? CYC_2 : CYC_1));
   endproperty
   a_brc: assert property (p_brc) else $error("conditional branch cycle count wrong");

   property p_ret;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && ctrl_en_ff && state_ff == ST_FETCH && opc == OPC_RETURN) |=> o_cycles == CYC_3;
   endproperty
   a_ret: assert property (p_ret) else $error("return not three cycles");

   property p_skip;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && ctrl_en_ff && state_ff == ST_FETCH && opc == OPC_SKIP && i_cond_true
         && is_long(i_next_word[OPC_LSB +: OPC_W])) |=> o_cycles == CYC_3;
   endproperty
   a_skip: assert property (p_skip) else $error("skip over long word not three cycles");

   property p_long;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && ctrl_en_ff && state_ff == ST_FETCH && is_long(opc)) |=> (!o_dec_valid && state_ff == ST_WORD2);
   endproperty
   a_long: assert property (p_long) else $error("long opcode did not wait");

   property p_sqr;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && ctrl_en_ff && state_ff == ST_FETCH && opc[7:2] == OPC_SQR_HI)
         |=> (o_mul_a == o_mul_b && o_mul_a[3:2] == 2'h1);
   endproperty
   a_sqr: assert property (p_sqr) else $error("square pair outside W4..W7");

   property p_mac;
      @(posedge i_ref_clk) disable iff (i_rst)
      (o_dec_valid && o_class == CL_DSP && o_mul_a != o_mul_b)
         |-> (o_mul_a < o_mul_b && o_mul_a[3:2] == 2'h1 && o_mul_b[3:2] == 2'h1);
   endproperty
   a_mac: assert property (p_mac) else $error("multiply pair malformed");

   property p_file;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && state_ff == ST_FETCH && opc == OPC_FILE && !w[FDEST_BIT]) |=> (o_wd == FILE_DEF_REG && !o_dest_file);
   endproperty
   a_file: assert property (p_file) else $error("file result not steered to W0");

   property p_lit;
      @(posedge i_ref_clk) disable iff (i_rst)
      (take && state_ff == ST_FETCH && w[BYTE_BIT]) |=> o_ten_bit_literal <= BYTE_LIT_MAX;
   endproperty
   a_lit: assert property (p_lit) else $error("byte literal above 255");

   property p_zs;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_res_valid && o_flag_mask[F_Z] && i_res_z_sticky && !o_status[F_Z]) |=> !o_status[F_Z];
   endproperty
   a_zs: assert property (p_zs) else $error("sticky zero was set");
endmodule

// ### verif/dsc_fetch_model.sv
// Program fetch model that offers words to the decoder
`timescale 1ns/1ps
module dsc_fetch_model (
   input  wire logic        i_ref_clk,
   output logic             o_valid,
   output logic [23:0]      o_word,
   output logic [23:0]      o_next,
   output logic             o_cond
);
   initial {o_valid, o_cond, o_word, o_next} = '0;
   // Offer one word with its follower and test result
   task put(input logic [23:0] w, input logic [23:0] n, input logic c);
      @(posedge i_ref_clk);
      o_valid <= 1'b1;
      o_word  <= w;
      o_next  <= n;
      o_cond  <= c;
   endtask
   // Release: stale word is inverted so nothing can lean on it
   task idle;
      @(posedge i_ref_clk);
      o_valid <= 1'b0;
      o_word  <= ~o_word;
      o_next  <= ~o_next;
   endtask
endmodule

// ### verif/dsc_decode_bench.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module dsc_decode_bench;
   import dsc_pkg::*;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, vld, cnd, i_wr_en = 1'b0, i_rd_en = 1'b0;
   logic [23:0] wd, nx;
   logic [3:0]  i_addr = 4'h0;
   logic [15:0] i_wr_data = 16'h0, o_rd_data;
   logic [22:0] tgt;
   logic [8:0]  sv, rf, i_res_flags = 9'h000;
   logic        i_res_valid = 1'b0, i_res_z_sticky = 1'b0;
   logic [5:0]  q[$], e;
   logic [1:0]  o_cycles, acc_wb;
   logic [3:0]  o_acc_wb_reg, acc_wb_inc, o_wd, mul_a, mul_b;
   logic        o_dec_valid;
   dsc_class_e  o_class;
   int n_fail = 0, num_checks = 0;
   always #2.5 i_ref_clk = ~i_ref_clk;
   dsc_fetch_model dsc_fetch_model_i (.i_ref_clk(i_ref_clk), .o_valid(vld), .o_word(wd), .o_next(nx), .o_cond(cnd));
   dsc_decode dsc_decode_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_instr_valid(vld), .i_instr_word(wd),
      .i_next_word(nx), .i_cond_true(cnd), .i_res_valid(i_res_valid), .i_res_flags(i_res_flags),
      .i_res_z_sticky(i_res_z_sticky), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_dec_valid(o_dec_valid), .o_class(o_class),
      .o_cycles(o_cycles), .o_wb(), .o_ws(), .o_wd(o_wd),
      .o_dest_file(), .o_file_addr(), .o_byte_mode(), .o_ten_bit_literal(), .o_bit_select_field(),
      .o_call_target_literal(tgt), .o_acc_sel(), .o_mul_a(mul_a), .o_mul_b(mul_b), .o_x_en(),
      .o_x_prefetch_addr_sel(), .o_x_adj(), .o_x_ofs_w12(), .o_x_dst(), .o_y_en(), .o_y_prefetch_addr_sel(),
      .o_y_adj(), .o_y_ofs_w12(), .o_y_dst(), .o_acc_writeback_dest(acc_wb), .o_acc_wb_reg(o_acc_wb_reg),
      .o_acc_wb_inc(acc_wb_inc), .o_flag_mask(), .o_status());
   task chk_dec(input logic [5:0] g, input logic [5:0] x);
      num_checks++;
      if (g !== x)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task chk_rd(input logic [15:0] g, input logic [15:0] x);
      num_checks++;
      if (g !== x)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   // Offer a word with random low operands and note the expected class and cycles
   task dec(input logic [7:0] op, input logic c, input logic [7:0] n, input logic [3:0] cl, input logic [1:0] cy);
      dsc_fetch_model_i.put({op, 16'($urandom) & 16'h0FFE}, {n, 16'h1234}, c);
      q.push_back({cl, cy});
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr_en   <= 1'b1;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr_en   <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] x);
      @(posedge i_ref_clk);
      i_rd_en <= 1'b1;
      i_addr  <= a;
      @(posedge i_ref_clk);
      i_rd_en <= 1'b0;
      @(negedge i_ref_clk);
      chk_rd(o_rd_data, x);
   endtask
   // Each decode pulse takes the oldest note; class 15 marks cycles-only notes
   always @(negedge i_ref_clk)
      if (o_dec_valid === 1'b1)
      begin
         e = q.pop_front();
         if (e[5:2] == 4'hF)
            chk_dec({4'h0, o_cycles}, {4'h0, e[1:0]});
         else
            chk_dec({o_class, o_cycles}, e);
      end
   task give_verdict;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog far beyond the fewer than a hundred cycles the tests need
   initial
   begin
      #100us;
      n_fail++;
      give_verdict();
   end
   initial
   begin
      void'($urandom(64068));
      repeat (12) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(negedge i_ref_clk);
      chk_rd({6'h0, o_cycles, o_acc_wb_reg, acc_wb_inc}, 16'h01D2);
      dec(8'h00, 0, 8'h00, CL_NOP, CYC_1);
      dec(8'h10, 1, 8'h00, CL_FILE, CYC_1);
      dec(8'h50, 1, 8'h00, CL_BRANCH, CYC_2);
      dec(8'h50, 0, 8'h00, CL_BRANCH, CYC_1);
      for (int k = 8'h51; k < 8'h57; k++)
         dec(8'(k), 0, 8'h00, 4'hF, CYC_2);
      dec(8'h57, 0, 8'h00, 4'hF, CYC_3);
      dec(8'h41, 1, 8'h70, CL_SKIP, CYC_3);
      dec(8'h41, 1, 8'h10, CL_SKIP, CYC_2);
      dec(8'h41, 0, 8'h70, CL_SKIP, CYC_1);
      dec(8'h60, 0, 8'h00, CL_MOVD, CYC_2);
      dec(8'h80, 0, 8'h00, CL_DSP, CYC_1);
      dec(8'hFF, 0, 8'h00, CL_ILLEGAL, CYC_1);
      // Pair field is zero in the random operands, so the pair is W4 by W5
      dec(8'hC1, 0, 8'h00, CL_DSP, CYC_1);
      dsc_fetch_model_i.idle();
      @(negedge i_ref_clk);
      chk_rd({8'h0, mul_a, mul_b}, 16'h0045);
      chk_rd({14'h0, acc_wb}, {14'h0, WB_DIR});
      dsc_fetch_model_i.put(24'h701234, 24'h00007F, 1'b0);
      dec(8'h00, 0, 8'h00, CL_LONG, CYC_2);
      dec(8'h00, 0, 8'h00, CL_NOP, CYC_1);
      dsc_fetch_model_i.idle();
      dsc_fetch_model_i.put(24'h711234, 24'h0, 1'b0);
      dsc_fetch_model_i.put(24'h00007F, 24'h0, 1'b0);
      q.push_back({CL_LONG, CYC_2});
      dsc_fetch_model_i.idle();
      @(negedge i_ref_clk);
      chk_rd({tgt[22:16], 9'h0}, {7'h7F, 9'h0});
      chk_rd(tgt[15:0], 16'h1234);
      // Only the illegal opcode has raised an error so far
      rd(A_ERR, 16'(1 << E_ILL));
      wr(A_ERR, 16'h000F);
      rd(A_ERR, 16'h0000);
      wr(A_CTRL, 16'h0000);
      dec(8'h51, 0, 8'h00, CL_NOP, CYC_1);
      dsc_fetch_model_i.idle();
      wr(A_CTRL, 16'h0001);
      sv = 9'($urandom) & ~9'h010;
      wr(A_STAT, {7'h0, sv});
      rd(A_STAT, {7'h0, sv});
      // Zero result bit set with sticky zero must leave a cleared zero flag cleared
      rf = 9'($urandom) | 9'h010;
      dec(OPC_FILE, 0, 8'h00, CL_FILE, CYC_1);
      dsc_fetch_model_i.idle();
      @(posedge i_ref_clk);
      i_res_valid    <= 1'b1;
      i_res_flags    <= rf;
      i_res_z_sticky <= 1'b1;
      @(posedge i_ref_clk);
      i_res_valid    <= 1'b0;
      rd(A_STAT, {7'h0, sv[8:5], 1'b0, rf[3:0]});
      rd(A_LAST, {2'h0, CL_FILE, CYC_1, OPC_FILE});
      chk_rd({12'h0, o_wd}, {12'h0, FILE_DEF_REG});
      rd(4'hF, 16'h0000);
      repeat (4) @(posedge i_ref_clk);
      chk_rd(16'(q.size()), 16'h0000);
      give_verdict();
   end
endmodule
